// ===== design/muldiv_pkg.sv
// Shared types and constants of the integer multiply/divide datapath
package muldiv_pkg;

    // Multiply/divide timing in pipeline clocks
    localparam int MUL_LAT_SHORT = 3;
    localparam int MUL_LAT_LONG = 4;
    localparam int MUL_REP_SHORT = 2;
    localparam int MUL_REP_LONG = 3;
    localparam int GPR_STALL_SHORT = 1;
    localparam int GPR_STALL_LONG = 2;
    localparam logic [5:0] DIV_LAT = 6'h24;
    localparam logic [5:0] DIV_STEPS = 6'h20;

    localparam int XLEN = 32;
    localparam logic [31:0] WORD_ZERO = 32'h0000_0000;

    // Pair update modes of a pending product
    localparam logic [1:0] MODE_SET = 2'h0;
    localparam logic [1:0] MODE_ADD = 2'h1;
    localparam logic [1:0] MODE_SUB = 2'h2;

    typedef enum logic [4:0] {
        OP_ADD = 5'h00,
        OP_SUB = 5'h01,
        OP_AND = 5'h02,
        OP_OR = 5'h03,
        OP_XOR = 5'h04,
        OP_NOR = 5'h05,
        OP_SHIFT_LEFT = 5'h06,
        OP_SHIFT_RIGHT = 5'h07,
        OP_SHIFT_RIGHT_ARITH = 5'h08,
        OP_SET_LESS = 5'h09,
        OP_SET_LESS_U = 5'h0A,
        OP_ADDR_CALC = 5'h0B,
        OP_COUNT_LEADING_SET_BITS = 5'h0C,
        OP_COUNT_LEADING_ZERO_BITS = 5'h0D,
        OP_READ_UPPER_RESULT = 5'h0E,
        OP_READ_BOTTOM_RESULT = 5'h0F,
        OP_SIGNED_PRODUCT_TO_PAIR = 5'h10,
        OP_UNSIGNED_PRODUCT_TO_PAIR = 5'h11,
        OP_PRODUCT_ACCUMULATE = 5'h12,
        OP_PRODUCT_ACCUMULATE_U = 5'h13,
        OP_PRODUCT_DEDUCT = 5'h14,
        OP_PRODUCT_DEDUCT_U = 5'h15,
        OP_PRODUCT_TO_GPR = 5'h16,
        OP_SIGNED_QUOTIENT = 5'h17,
        OP_UNSIGNED_QUOTIENT_OP = 5'h18
    } op_t;

    typedef enum logic [1:0] {
        DIV_IDLE = 2'b01,
        DIV_RUN = 2'b10
    } div_state_t;

    typedef struct packed {
        op_t op;
        logic [4:0] src_a;
        logic [4:0] src_b;
        logic [4:0] dst;
        logic use_imm;
        logic [31:0] imm;
    } op_req_t;

    typedef struct packed {
        logic en;
        logic [4:0] idx;
        logic [31:0] data;
    } gpr_wr_t;

    typedef struct packed {
        logic valid;
        logic to_gpr;
        logic [1:0] mode;
        logic [4:0] dst;
        logic [63:0] prod;
    } mul_entry_t;

endpackage

// ===== design/gpr_file.sv
// General-purpose register file: 32 words, two registered reads, two writes
`timescale 1ns/1ps
`default_nettype none
module gpr_file
    import muldiv_pkg::*;
(
    input wire logic i_clk,
    input wire logic [4:0] i_rd_a_idx,
    input wire logic [4:0] i_rd_b_idx,
    output logic [31:0] o_rd_a_ff,
    output logic [31:0] o_rd_b_ff,
    input wire gpr_wr_t i_wr_a,
    input wire gpr_wr_t i_wr_b
);
    logic [31:0] mem_ff [32];

    // Reads return the value before this edge's writes
    always_ff @(posedge i_clk)
    begin
        o_rd_a_ff <= mem_ff[i_rd_a_idx];
        o_rd_b_ff <= mem_ff[i_rd_b_idx];
    end

    // Port A wins on a same-index double write
    always_ff @(posedge i_clk)
    begin
        if (i_wr_b.en)
        begin
            mem_ff[i_wr_b.idx] <= i_wr_b.data;
        end
        if (i_wr_a.en)
        begin
            mem_ff[i_wr_a.idx] <= i_wr_a.data;
        end
    end
endmodule // gpr_file
`default_nettype wire

// ===== design/integer_muldiv_datapath.sv
// Integer execution stage: ALU, register file and multiply/divide unit
`timescale 1ns/1ps
`default_nettype none
// Operation
// - Pair multiplies: latency 3/4, repeat 2/3
// - Product-to-register: latency 3/4, stalls 1/2
// - Divides: 37 latency, 36 repeat, no stall
// - All counts are pipeline clock cycles
// - Pair multiply and divide write result pair
// - Read ops copy pair register to GPR
// - Product-to-register writes GPR directly
// - Accumulate adds product to pair atomically
// - Deduct subtracts product from pair atomically
// - Multiplier pipelined, reissue before completion
// - Operand size detected, 16-bit timing used
// - Interlocks stall on pending results, busy unit
// - 32x32 register file, two reads, two writes
// - Results bypassed to dependent operations
// - ALU operations finish in one cycle
// - Adder shared with address calculation
// - Count leading ones and zeros
module integer_muldiv_datapath
    import muldiv_pkg::*;
(
    input wire logic i_clk,
    input wire logic i_sys_rst,
    input wire logic i_req_valid,
    input wire op_req_t i_req,
    output logic o_gen_ready_ff,
    output logic o_mdu_ready_ff,
    output logic o_pair_ready_ff,
    output logic [31:0] o_result_ff,
    output logic o_result_valid_ff,
    output logic [31:0] o_addr_ff,
    output logic o_addr_valid_ff,
    output logic [31:0] o_upper_result_ff,
    output logic [31:0] o_bottom_result_ff
);
    logic req_mdu, req_pair_read, req_pair_write, req_to_gpr, take;
    logic ex_valid_ff;
    op_req_t ex_req_ff;
    logic [31:0] rf_a, rf_b, opa, opb_reg, opb;
    gpr_wr_t wr_a, wr_b, byp_a_ff, byp_b_ff;
    logic ex_mdu, ex_div, ex_mul, ex_to_gpr, ex_signed, fits16, long_mul;
    logic ex_alu, ex_pair_write;
    logic signed [32:0] mul_a, mul_b;
    logic signed [65:0] prod_full;
    mul_entry_t ent, p0_ff, p1_ff;
    div_state_t div_state_ff;
    logic [5:0] div_cnt_ff;
    logic [31:0] rem_ff, quo_ff, den_ff;
    logic neg_q_ff, neg_r_ff, div_commit, div_holding;
    logic [32:0] rem_sh, diff;
    logic [31:0] sum, alu_res;
    logic nxt_gen_ready, nxt_mdu_ready, nxt_pair_ready;

    function automatic logic [5:0] lead_zeros(input logic [31:0] v);
        logic [5:0] n;
        logic hit;
        n = 6'h20;
        hit = 1'b0;
        for (int i = XLEN - 1; i >= 0; i--)
        begin
            if (!hit && v[i])
            begin
                n = 6'(XLEN - 1 - i);
                hit = 1'b1;
            end
        end
        return n;
    endfunction

    // Issue decode
    assign req_mdu = (i_req.op >= OP_SIGNED_PRODUCT_TO_PAIR);
    assign req_to_gpr = (i_req.op == OP_PRODUCT_TO_GPR);
    assign req_pair_read = (i_req.op == OP_READ_UPPER_RESULT) ||
        (i_req.op == OP_READ_BOTTOM_RESULT);
    assign req_pair_write = req_mdu && !req_to_gpr;
    // Issue interlocks
    assign take = i_req_valid && (req_mdu ? o_mdu_ready_ff :
        (o_gen_ready_ff && (!req_pair_read || o_pair_ready_ff)));

    always_ff @(posedge i_clk)
    begin
        if (i_sys_rst)
        begin
            ex_valid_ff <= 1'b0;
            ex_req_ff <= '0;
        end
        else
        begin
            ex_valid_ff <= take;
            ex_req_ff <= i_req;
        end
    end

    gpr_file u_gpr_file (
        .i_clk(i_clk),
        .i_rd_a_idx(i_req.src_a),
        .i_rd_b_idx(i_req.src_b),
        .o_rd_a_ff(rf_a),
        .o_rd_b_ff(rf_b),
        .i_wr_a(wr_a),
        .i_wr_b(wr_b)
    );

    // Writes of the read edge, replayed into the operands
    always_ff @(posedge i_clk)
    begin
        if (i_sys_rst)
        begin
            byp_a_ff <= '0;
            byp_b_ff <= '0;
        end
        else
        begin
            byp_a_ff <= wr_a;
            byp_b_ff <= wr_b;
        end
    end

    always_comb
    begin
        opa = rf_a;
        opb_reg = rf_b;
        if (byp_a_ff.en && byp_a_ff.idx == ex_req_ff.src_a)
            opa = byp_a_ff.data;
        else if (byp_b_ff.en && byp_b_ff.idx == ex_req_ff.src_a)
            opa = byp_b_ff.data;
        if (byp_a_ff.en && byp_a_ff.idx == ex_req_ff.src_b)
            opb_reg = byp_a_ff.data;
        else if (byp_b_ff.en && byp_b_ff.idx == ex_req_ff.src_b)
            opb_reg = byp_b_ff.data;
        opb = ex_req_ff.use_imm ? ex_req_ff.imm : opb_reg;
    end

    // Execute-stage decode
    assign ex_mdu = ex_valid_ff && (ex_req_ff.op >= OP_SIGNED_PRODUCT_TO_PAIR);
    assign ex_div = ex_valid_ff && (ex_req_ff.op >= OP_SIGNED_QUOTIENT);
    assign ex_mul = ex_mdu && !ex_div;
    assign ex_to_gpr = ex_valid_ff && (ex_req_ff.op == OP_PRODUCT_TO_GPR);
    assign ex_pair_write = ex_mdu && !ex_to_gpr;
    assign ex_alu = ex_valid_ff && !ex_mdu;
    assign ex_signed = !((ex_req_ff.op == OP_UNSIGNED_PRODUCT_TO_PAIR) ||
        (ex_req_ff.op == OP_PRODUCT_ACCUMULATE_U) || (ex_req_ff.op == OP_PRODUCT_DEDUCT_U) ||
        (ex_req_ff.op == OP_UNSIGNED_QUOTIENT_OP));

    // Operand size detection
    assign fits16 = ex_signed ?
        ((&opa[31:15] || ~|opa[31:15]) && (&opb[31:15] || ~|opb[31:15])) :
        (~|opa[31:16] && ~|opb[31:16]);
    assign long_mul = ex_mul && !fits16;

    assign mul_a = {ex_signed && opa[31], opa};
    assign mul_b = {ex_signed && opb[31], opb};
    assign prod_full = mul_a * mul_b;

    always_comb
    begin
        ent = '0;
        ent.valid = ex_mul;
        ent.to_gpr = ex_to_gpr;
        ent.dst = ex_req_ff.dst;
        ent.prod = prod_full[63:0];
        case (ex_req_ff.op)
            OP_PRODUCT_ACCUMULATE, OP_PRODUCT_ACCUMULATE_U: ent.mode = MODE_ADD;
            OP_PRODUCT_DEDUCT, OP_PRODUCT_DEDUCT_U: ent.mode = MODE_SUB;
            default: ent.mode = MODE_SET;
        endcase
    end

    // Product pipeline, entry point set by latency
    always_ff @(posedge i_clk)
    begin
        if (i_sys_rst)
        begin
            p0_ff <= '0;
            p1_ff <= '0;
        end
        else
        begin
            p0_ff <= '0;
            p1_ff <= p0_ff;
            if (ex_mul && (fits16 ? MUL_LAT_SHORT : MUL_LAT_LONG) == MUL_LAT_LONG)
                p0_ff <= ent;
            else if (ex_mul)
                p1_ff <= ent;
        end
    end

    // Product-to-register goes straight to write port B
    always_comb
    begin
        wr_b.en = p1_ff.valid && p1_ff.to_gpr;
        wr_b.idx = p1_ff.dst;
        wr_b.data = p1_ff.prod[31:0];
    end

    // Restoring divider step
    assign rem_sh = {rem_ff, quo_ff[31]};
    assign diff = rem_sh - {1'b0, den_ff};
    assign div_commit = (div_state_ff == DIV_RUN) && (div_cnt_ff == DIV_LAT - 6'h01);
    assign div_holding = (div_state_ff == DIV_RUN) && (div_cnt_ff < DIV_LAT - 6'h02);

    always_ff @(posedge i_clk)
    begin
        if (i_sys_rst)
        begin
            div_state_ff <= DIV_IDLE;
            div_cnt_ff <= 6'h00;
            rem_ff <= WORD_ZERO;
            quo_ff <= WORD_ZERO;
            den_ff <= WORD_ZERO;
            neg_q_ff <= 1'b0;
            neg_r_ff <= 1'b0;
        end
        else
        begin
            case (div_state_ff)
                DIV_IDLE:
                begin
                    if (ex_div)
                    begin
                        div_state_ff <= DIV_RUN;
                        div_cnt_ff <= 6'h01;
                        rem_ff <= WORD_ZERO;
                        quo_ff <= (ex_signed && opa[31]) ? -opa : opa;
                        den_ff <= (ex_signed && opb[31]) ? -opb : opb;
                        neg_q_ff <= ex_signed && (opa[31] ^ opb[31]);
                        neg_r_ff <= ex_signed && opa[31];
                    end
                end
                DIV_RUN:
                begin
                    div_cnt_ff <= div_cnt_ff + 6'h01;
                    if (div_cnt_ff <= DIV_STEPS)
                    begin
                        rem_ff <= diff[32] ? rem_sh[31:0] : diff[31:0];
                        quo_ff <= {quo_ff[30:0], ~diff[32]};
                    end
                    if (div_commit)
                        div_state_ff <= DIV_IDLE;
                end
                default: div_state_ff <= DIV_IDLE;
            endcase
        end
    end

    // Result pair: set, accumulate, deduct, divide
    always_ff @(posedge i_clk)
    begin
        if (i_sys_rst)
        begin
            o_upper_result_ff <= WORD_ZERO;
            o_bottom_result_ff <= WORD_ZERO;
        end
        else if (div_commit)
        begin
            o_upper_result_ff <= neg_r_ff ? -rem_ff : rem_ff;
            o_bottom_result_ff <= neg_q_ff ? -quo_ff : quo_ff;
        end
        else if (p1_ff.valid && !p1_ff.to_gpr)
        begin
            case (p1_ff.mode)
                MODE_ADD:
                    {o_upper_result_ff, o_bottom_result_ff} <=
                        {o_upper_result_ff, o_bottom_result_ff} + p1_ff.prod;
                MODE_SUB:
                    {o_upper_result_ff, o_bottom_result_ff} <=
                        {o_upper_result_ff, o_bottom_result_ff} - p1_ff.prod;
                default: {o_upper_result_ff, o_bottom_result_ff} <= p1_ff.prod;
            endcase
        end
    end

    // Single-cycle ALU with the shared adder
    assign sum = opa + opb;
    always_comb
    begin
        case (ex_req_ff.op)
            OP_ADD, OP_ADDR_CALC: alu_res = sum;
            OP_SUB: alu_res = opa - opb;
            OP_AND: alu_res = opa & opb;
            OP_OR: alu_res = opa | opb;
            OP_XOR: alu_res = opa ^ opb;
            OP_NOR: alu_res = ~(opa | opb);
            OP_SHIFT_LEFT: alu_res = opa << opb[4:0];
            OP_SHIFT_RIGHT: alu_res = opa >> opb[4:0];
            OP_SHIFT_RIGHT_ARITH: alu_res = 32'($signed(opa) >>> opb[4:0]);
            OP_SET_LESS: alu_res = {31'h0, $signed(opa) < $signed(opb)};
            OP_SET_LESS_U: alu_res = {31'h0, opa < opb};
            OP_COUNT_LEADING_SET_BITS: alu_res = {26'h0, lead_zeros(~opa)};
            OP_COUNT_LEADING_ZERO_BITS: alu_res = {26'h0, lead_zeros(opa)};
            OP_READ_UPPER_RESULT: alu_res = o_upper_result_ff;
            OP_READ_BOTTOM_RESULT: alu_res = o_bottom_result_ff;
            default: alu_res = WORD_ZERO;
        endcase
    end

    always_comb
    begin
        wr_a.en = ex_alu && (ex_req_ff.op != OP_ADDR_CALC);
        wr_a.idx = ex_req_ff.dst;
        wr_a.data = alu_res;
    end

    always_ff @(posedge i_clk)
    begin
        if (i_sys_rst)
        begin
            o_result_ff <= WORD_ZERO;
            o_result_valid_ff <= 1'b0;
            o_addr_ff <= WORD_ZERO;
            o_addr_valid_ff <= 1'b0;
        end
        else
        begin
            o_result_valid_ff <= wr_a.en;
            o_addr_valid_ff <= ex_alu && (ex_req_ff.op == OP_ADDR_CALC);
            if (wr_a.en)
                o_result_ff <= alu_res;
            if (ex_alu && ex_req_ff.op == OP_ADDR_CALC)
                o_addr_ff <= sum;
        end
    end

    // Ready flags, all counted in pipeline clocks
    assign nxt_gen_ready = !(take && req_to_gpr) && !(long_mul && ex_to_gpr);
    assign nxt_mdu_ready = !(take && req_mdu) && !long_mul && !ex_div &&
        !div_holding;
    assign nxt_pair_ready = !(take && req_pair_write) && !(long_mul && ex_pair_write) &&
        !ex_div && !div_holding;

    always_ff @(posedge i_clk)
    begin
        if (i_sys_rst)
        begin
            o_gen_ready_ff <= 1'b1;
            o_mdu_ready_ff <= 1'b1;
            o_pair_ready_ff <= 1'b1;
        end
        else
        begin
            o_gen_ready_ff <= nxt_gen_ready;
            o_mdu_ready_ff <= nxt_mdu_ready;
            o_pair_ready_ff <= nxt_pair_ready;
        end
    end

    // Checks
    short_pair_lat_a: assert property (@(posedge i_clk) disable iff (i_sys_rst)
        ex_mul && fits16 && !ex_to_gpr && ent.mode == MODE_SET |->
        ##2 {o_upper_result_ff, o_bottom_result_ff} == $past(ent.prod, 2))
        else $error("short pair product late or wrong");

    long_pair_lat_a: assert property (@(posedge i_clk) disable iff (i_sys_rst)
        ex_mul && !fits16 && !ex_to_gpr && ent.mode == MODE_SET |->
        ##3 o_upper_result_ff == $past(prod_full[63:32], 3))
        else $error("long pair product late or wrong");

    gpr_stall_a: assert property (@(posedge i_clk) disable iff (i_sys_rst)
        long_mul && ex_to_gpr |-> !o_gen_ready_ff ##1 !o_gen_ready_ff ##1 o_gen_ready_ff)
        else $error("product-to-register stall length wrong");

    div_repeat_a: assert property (@(posedge i_clk) disable iff (i_sys_rst)
        ex_div |=> ##33 !o_mdu_ready_ff ##1 (o_mdu_ready_ff && o_pair_ready_ff))
        else $error("divide reissue interval wrong");

    pair_read_a: assert property (@(posedge i_clk) disable iff (i_sys_rst)
        ex_valid_ff && ex_req_ff.op == OP_READ_UPPER_RESULT |=>
        o_result_valid_ff && o_result_ff == $past(o_upper_result_ff))
        else $error("upper result copy wrong");

    accumulate_a: assert property (@(posedge i_clk) disable iff (i_sys_rst)
        p1_ff.valid && !p1_ff.to_gpr && p1_ff.mode == MODE_ADD |=>
        {o_upper_result_ff, o_bottom_result_ff} ==
        $past({o_upper_result_ff, o_bottom_result_ff}) + $past(p1_ff.prod))
        else $error("accumulate result wrong");

    deduct_a: assert property (@(posedge i_clk) disable iff (i_sys_rst)
        p1_ff.valid && !p1_ff.to_gpr && p1_ff.mode == MODE_SUB |=>
        {o_upper_result_ff, o_bottom_result_ff} ==
        $past({o_upper_result_ff, o_bottom_result_ff}) - $past(p1_ff.prod))
        else $error("deduct result wrong");

    read_interlock_a: assert property (@(posedge i_clk) disable iff (i_sys_rst)
        take && req_pair_read |-> !(p0_ff.valid && !p0_ff.to_gpr) && !ex_pair_write &&
        (div_state_ff == DIV_IDLE || div_commit))
        else $error("pair read issued while pair pending");

    lead_zero_a: assert property (@(posedge i_clk) disable iff (i_sys_rst)
        ex_valid_ff && ex_req_ff.op == OP_COUNT_LEADING_ZERO_BITS |=>
        (o_result_ff == 32'h0000_0020) == ($past(opa) == WORD_ZERO))
        else $error("leading zero count wrong");

    alu_single_a: assert property (@(posedge i_clk) disable iff (i_sys_rst)
        take && !req_mdu |=> ##1 (o_result_valid_ff || o_addr_valid_ff))
        else $error("ALU result not after one cycle");

    short_mul_c: cover property (@(posedge i_clk) disable iff (i_sys_rst)
        ex_mul && fits16 ##1 take && req_mdu);
    accumulate_c: cover property (@(posedge i_clk) disable iff (i_sys_rst)
        p1_ff.valid && p1_ff.mode == MODE_ADD);
    divide_c: cover property (@(posedge i_clk) disable iff (i_sys_rst) div_commit);
    bypass_c: cover property (@(posedge i_clk) disable iff (i_sys_rst)
        ex_valid_ff && byp_b_ff.en && byp_b_ff.idx == ex_req_ff.src_a);

endmodule // integer_muldiv_datapath
`default_nettype wire

// ===== tb/pipe_issuer.sv
// Pipeline issue model: holds one request until the datapath takes it
`timescale 1ns/1ps
`default_nettype none
module pipe_issuer
    import muldiv_pkg::*;
(
    input wire logic i_clk,
    input wire logic i_sys_rst,
    input wire logic i_cmd_valid,
    input wire op_req_t i_cmd,
    input wire logic i_gen_ready,
    input wire logic i_mdu_ready,
    input wire logic i_pair_ready,
    output logic o_req_valid,
    output op_req_t o_req,
    output logic o_taken
);
    logic is_mdu;
    logic is_rd;
    assign is_mdu = (o_req.op >= OP_SIGNED_PRODUCT_TO_PAIR);
    assign is_rd = (o_req.op == OP_READ_UPPER_RESULT) || (o_req.op == OP_READ_BOTTOM_RESULT);
    assign o_taken = o_req_valid &&
        (is_mdu ? i_mdu_ready : i_gen_ready && (!is_rd || i_pair_ready));
    always_ff @(posedge i_clk)
    begin
        if (i_sys_rst)
            o_req_valid <= 1'b0;
        else if (i_cmd_valid)
            o_req_valid <= 1'b1;
        else if (o_taken)
            o_req_valid <= 1'b0;
    end
    // Released request lines toggle instead of holding
    always_ff @(posedge i_clk)
    begin
        if (i_cmd_valid)
            o_req <= i_cmd;
        else if (!o_req_valid || o_taken)
            o_req <= op_req_t'(~o_req);
    end
endmodule // pipe_issuer
`default_nettype wire

// ===== tb/testbench.sv
// Self-checking bench for the integer multiply/divide datapath
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, e, g) begin samples_checked++; if ((g) !== (e)) begin n_fail++; \
    $display("MISMATCH %s exp=%h got=%h", nm, e, g); end end
module testbench
    import muldiv_pkg::*;
();
    logic i_clk;
    logic i_sys_rst = 1'b1;
    logic cmd_valid = 1'b0;
    op_req_t cmd = '0;
    logic req_valid, taken, gen_rdy, mdu_rdy, pair_rdy, res_v, addr_v;
    op_req_t req;
    logic [31:0] result, addr, upper, bottom;
    logic [63:0] old_pair;
    int cyc = 0;
    int t_take = 0;
    int t1 = 0;
    int n_fail = 0;
    int samples_checked = 0;
    op_t alu_op [13] = '{OP_ADD, OP_SUB, OP_AND, OP_OR, OP_XOR, OP_NOR, OP_SHIFT_LEFT,
        OP_SHIFT_RIGHT, OP_SHIFT_RIGHT_ARITH, OP_SET_LESS, OP_SET_LESS_U,
        OP_COUNT_LEADING_SET_BITS, OP_COUNT_LEADING_ZERO_BITS};
    logic [31:0] alu_exp [13] = '{32'hF000_00F4, 32'hF000_00EC, 32'h0, 32'hF000_00F4,
        32'hF000_00F4, 32'h0FFF_FF0B, 32'h0000_0F00, 32'h0F00_000F, 32'hFF00_000F,
        32'h1, 32'h0, 32'h4, 32'h0};

    integer_muldiv_datapath uut (.i_clk(i_clk), .i_sys_rst(i_sys_rst),
        .i_req_valid(req_valid), .i_req(req), .o_gen_ready_ff(gen_rdy),
        .o_mdu_ready_ff(mdu_rdy), .o_pair_ready_ff(pair_rdy), .o_result_ff(result),
        .o_result_valid_ff(res_v), .o_addr_ff(addr), .o_addr_valid_ff(addr_v),
        .o_upper_result_ff(upper), .o_bottom_result_ff(bottom));
    pipe_issuer issuer (.i_clk(i_clk), .i_sys_rst(i_sys_rst), .i_cmd_valid(cmd_valid),
        .i_cmd(cmd), .i_gen_ready(gen_rdy), .i_mdu_ready(mdu_rdy),
        .i_pair_ready(pair_rdy), .o_req_valid(req_valid), .o_req(req), .o_taken(taken));

    initial
    begin
        i_clk = 1'b0;
        forever #12.5 i_clk = ~i_clk;
    end

    task automatic finish_test();
        $display("checks=%0d mismatches=%0d", samples_checked, n_fail);
        if (n_fail == 0 && samples_checked > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask

    always @(posedge i_clk)
    begin
        cyc <= cyc + 1;
        if (cyc > 4000)
        begin
            n_fail++;
            finish_test();
        end
    end

    // Returns on the edge the held request is taken
    task automatic wait_take();
        int n;
        n = 0;
        while (n < 100)
        begin
            @(posedge i_clk);
            n++;
            if (taken === 1'b1)
                break;
        end
        if (taken !== 1'b1)
        begin
            n_fail++;
            finish_test();
        end
        t_take = cyc;
    endtask

    // Called on a rising edge; returns on the edge the request is taken
    task automatic issue(input op_t op, input logic [4:0] a, b, d, input logic ui,
        input logic [31:0] imm);
        cmd_valid <= 1'b1;
        cmd <= '{op, a, b, d, ui, imm};
        @(posedge i_clk);
        cmd_valid <= 1'b0;
        wait_take();
    endtask

    // Queues c2 behind c1 so c2 can be taken right after c1
    task automatic issue_two(input op_req_t c1, input op_req_t c2);
        cmd_valid <= 1'b1;
        cmd <= c1;
        @(posedge i_clk);
        cmd <= c2;
        @(posedge i_clk);
        cmd_valid <= 1'b0;
        t1 = cyc;
        `CHK("take1", 1'b1, taken)
        wait_take();
    endtask

    // Reads state left by edge t_take+k-1
    task automatic at(input int k);
        while (cyc != t_take + k)
            @(posedge i_clk);
    endtask

    task automatic set_reg(input logic [4:0] r, input logic [31:0] v);
        issue(OP_AND, r, 5'h0, r, 1'b1, 32'h0);
        issue(OP_OR, r, 5'h0, r, 1'b1, v);
        at(2);
        `CHK("gpr", v, result)
    endtask

    task automatic t_alu();
        for (int i = 0; i < 13; i++)
        begin
            issue(alu_op[i], 5'h1, 5'h0, 5'h8, 1'b1, 32'h4);
            at(2);
            `CHK("res_v", 1'b1, res_v)
            `CHK("alu", alu_exp[i], result)
        end
        issue(OP_ADDR_CALC, 5'h1, 5'h0, 5'h0, 1'b1, 32'h4);
        at(2);
        `CHK("addr", 32'hF000_00F4, addr)
        `CHK("addr_v", 1'b1, addr_v)
        issue_two('{OP_ADD, 5'h1, 5'h0, 5'h9, 1'b1, 32'h4},
            '{OP_ADD, 5'h9, 5'h9, 5'hA, 1'b0, 32'h0});
        `CHK("b2b_gap", 1, t_take - t1)
        at(2);
        `CHK("bypass", 32'hE000_01E8, result)
    endtask

    task automatic mul_pair(input op_t op, input logic [4:0] a, b, input int lat,
        input logic [63:0] e);
        issue(op, a, b, 5'h0, 1'b0, 32'h0);
        old_pair = {upper, bottom};
        at(1);
        `CHK("mdu_rdy", 1'b0, mdu_rdy)
        `CHK("pair_rdy", 1'b0, pair_rdy)
        at(lat - 1);
        `CHK("mdu_rdy", 1'b1, mdu_rdy)
        `CHK("pair_rdy", 1'b1, pair_rdy)
        `CHK("pair", old_pair, {upper, bottom})
        at(lat);
        `CHK("pair", e, {upper, bottom})
    endtask

    task automatic t_repeat();
        issue(OP_SIGNED_PRODUCT_TO_PAIR, 5'h2, 5'h3, 5'h0, 1'b0, 32'h0);
        t1 = t_take;
        issue(OP_SIGNED_PRODUCT_TO_PAIR, 5'h2, 5'h3, 5'h0, 1'b0, 32'h0);
        `CHK("gap16", 2, t_take - t1)
        issue(OP_UNSIGNED_PRODUCT_TO_PAIR, 5'h2, 5'h3, 5'h0, 1'b0, 32'h0);
        t1 = t_take;
        issue(OP_UNSIGNED_PRODUCT_TO_PAIR, 5'h2, 5'h3, 5'h0, 1'b0, 32'h0);
        `CHK("gap32", 3, t_take - t1)
        issue(OP_READ_UPPER_RESULT, 5'h0, 5'h0, 5'h4, 1'b0, 32'h0);
        at(2);
        `CHK("upper", 32'h6, result)
        issue(OP_READ_BOTTOM_RESULT, 5'h0, 5'h0, 5'h4, 1'b0, 32'h0);
        at(2);
        `CHK("bottom", 32'hFFFF_FFEB, result)
        issue(OP_PRODUCT_ACCUMULATE_U, 5'h3, 5'h3, 5'h0, 1'b0, 32'h0);
        issue(OP_READ_BOTTOM_RESULT, 5'h0, 5'h0, 5'h4, 1'b0, 32'h0);
        at(2);
        `CHK("acc_rd", 32'h1C, result)
    endtask

    task automatic t_gpr();
        issue(OP_PRODUCT_TO_GPR, 5'h2, 5'h3, 5'h5, 1'b0, 32'h0);
        at(1);
        `CHK("gen_rdy", 1'b0, gen_rdy)
        at(2);
        `CHK("gen_rdy", 1'b1, gen_rdy)
        issue(OP_OR, 5'h5, 5'h0, 5'h9, 1'b1, 32'h0);
        at(2);
        `CHK("gpr", 32'hFFFF_FFEB, result)
        `CHK("bottom", 32'h1C, bottom)
        issue_two('{OP_PRODUCT_TO_GPR, 5'h1, 5'h3, 5'hB, 1'b0, 32'h0},
            '{OP_OR, 5'hB, 5'h0, 5'hC, 1'b1, 32'h0});
        `CHK("stall32", 3, t_take - t1)
        at(2);
        `CHK("gpr_byp", 32'h9000_0690, result)
    endtask

    task automatic t_div(input op_t op, input logic [4:0] a, b, input logic [31:0] q, r);
        issue(op, a, b, 5'h0, 1'b0, 32'h0);
        old_pair = {upper, bottom};
        at(35);
        `CHK("mdu_rdy", 1'b0, mdu_rdy)
        `CHK("gen_rdy", 1'b1, gen_rdy)
        at(36);
        `CHK("mdu_rdy", 1'b1, mdu_rdy)
        `CHK("pair", old_pair, {upper, bottom})
        at(37);
        `CHK("div", {r, q}, {upper, bottom})
    endtask

    initial
    begin
        repeat (20) @(posedge i_clk);
        i_sys_rst <= 1'b0;
        @(posedge i_clk);
        `CHK("rdy", 3'b111, {gen_rdy, mdu_rdy, pair_rdy})
        `CHK("pair", 64'h0, {upper, bottom})
        set_reg(5'h1, 32'hF000_00F0);
        set_reg(5'h2, 32'hFFFF_FFFD);
        set_reg(5'h3, 32'h7);
        set_reg(5'h6, 32'h64);
        t_alu();
        t_repeat();
        t_gpr();
        mul_pair(OP_SIGNED_PRODUCT_TO_PAIR, 5'h2, 5'h3, 3, 64'hFFFF_FFFF_FFFF_FFEB);
        mul_pair(OP_UNSIGNED_PRODUCT_TO_PAIR, 5'h2, 5'h3, 4, 64'h6_FFFF_FFEB);
        mul_pair(OP_PRODUCT_ACCUMULATE, 5'h2, 5'h3, 3, 64'h6_FFFF_FFD6);
        mul_pair(OP_PRODUCT_DEDUCT, 5'h2, 5'h3, 3, 64'h6_FFFF_FFEB);
        mul_pair(OP_PRODUCT_ACCUMULATE_U, 5'h3, 5'h3, 3, 64'h7_0000_001C);
        mul_pair(OP_PRODUCT_DEDUCT_U, 5'h3, 5'h3, 3, 64'h6_FFFF_FFEB);
        t_div(OP_UNSIGNED_QUOTIENT_OP, 5'h6, 5'h3, 32'hE, 32'h2);
        t_div(OP_SIGNED_QUOTIENT, 5'h2, 5'h3, 32'h0, 32'hFFFF_FFFD);
        finish_test();
    end
endmodule // testbench
`default_nettype wire
